/* File: rtl/tls_pkg.sv */
// Purpose: constants for the trajectory load and start block
// Assumes: APB register access, 32-bit aligned words
// Notes: offsets are byte addresses
package tls_pkg;
  localparam logic [7:0] CMD_LOAD_TRAJ = 8'h1f;
  localparam logic [7:0] CMD_START = 8'h01;
  localparam logic [7:0] CMD_LOAD_FILT = 8'h1e;
  localparam logic [7:0] CMD_UPD_FILT = 8'h04;
  // control word field positions
  localparam int CW_POS_REL = 0;
  localparam int CW_POS_LD = 1;
  localparam int CW_VEL_REL = 2;
  localparam int CW_VEL_LD = 3;
  localparam int CW_ACC_REL = 4;
  localparam int CW_ACC_LD = 5;
  localparam int CW_OFF = 8;
  localparam int CW_ABRUPT = 9;
  localparam int CW_SMOOTH = 10;
  localparam int CW_VMODE = 11;
  localparam int CW_FWD = 12;
  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_CMDERR = 1;
  localparam int ST_DONE = 2;
  localparam int ST_OFF = 7;
  // one interval step is 2048 system clocks; only its length in time scales with the clock
  localparam int SAMPLE_REF_CLKS = 2048;
  localparam int SAMPLE_REF_MHZ = 8;
  localparam int CLK_MHZ = 250;
  localparam int SAMPLE_CLKS = SAMPLE_REF_CLKS;
  localparam int BUSY_CLKS = 4;
  localparam logic [31:0] ACC_MAX = 32'h3fffffff;
  localparam logic [31:0] POS_MIN = 32'hc0000000;
  localparam logic [31:0] POS_MAX = 32'h3fffffff;
  localparam logic [7:0] DRIVE_ZERO = 8'h80;
  // register byte offsets
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_DATA = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_SIGNALS = 8'h0c;
  localparam logic [7:0] A_ACC = 8'h10;
  localparam logic [7:0] A_VEL = 8'h14;
  localparam logic [7:0] A_POS = 8'h18;
  localparam logic [7:0] A_ACTUAL = 8'h1c;
  localparam logic [7:0] A_DONE = 8'h20;
  localparam logic [7:0] A_RSTI = 8'h24;
  localparam logic [7:0] A_SINT = 8'h28;
endpackage

/* File: rtl/tls_top.sv */
// Purpose: trajectory command interpreter with double-buffered parameters
// Assumes: host writes command and data bytes via APB, one byte per write
// Notes: profile generator and filter are outside; this block holds state
//
// Summary of operation
// RULE1 - first two data bytes form control word
// RULE2 - sample interval is (N+1) times 2048 clocks
// RULE3 - direction bit used only in velocity mode
// RULE4 - bit 11 selects velocity or position mode
// RULE5 - position mode stops at trajectory end automatically
// RULE6 - bit 8 stop drives zero output code
// RULE7 - bit 9 stop sets target to present
// RULE8 - bit 10 stop decelerates with programmed acceleration
// RULE9 - host sets at most one stop bit
// RULE10 - load and relative flags per parameter
// RULE11 - each parameter two words, MSB first
// RULE12 - order acceleration, velocity, position; skip clear
// RULE13 - acceleration and velocity limited unsigned fixed point
// RULE14 - position limited signed range
// RULE15 - host keeps acceleration not above velocity
// RULE16 - loads buffered until start command copies
// RULE17 - start code 01 no data bytes
// RULE18 - start during motion after acc change errors
// RULE19 - host waits before start after acc change
// RULE20 - start takes effect at next sample boundary
// RULE21 - host checks busy before each pair
// RULE22 - bytes written while busy discarded silently
// RULE23 - direction and motor off change at start
// RULE24 - expected data bytes four per load flag
// RULE25 - relative values added to buffered value
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module tls_top
  import tls_pkg::*;
#(
  parameter int SAMPLE_CLKS_P = SAMPLE_CLKS
) (
  input wire logic CLK, // system clock
  input wire logic SYS_RST, // synchronous reset, high
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb direction
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error
  output logic [31:0] TGT_ACC, // working acceleration
  output logic [31:0] TGT_VEL, // working velocity
  output logic [31:0] TGT_POS, // working target position
  output logic VEL_MODE, // working mode, 1 velocity
  output logic FWD_DIR, // working direction
  output logic MOTOR_OFF, // drive held at zero code
  output logic [7:0] DRIVE_CODE, // offset binary drive when stopped
  output logic SMOOTH_STOP, // decelerate with working acceleration
  output logic IN_MOTION, // trajectory running
  output logic SAMPLE_TICK // one pulse per sample interval
);
  typedef enum logic [1:0] {S_IDLE, S_CW, S_DATA} tls_state_t;
  tls_state_t state_ff;
  logic [15:0] cw_ff;
  logic [3:0] cnt_ff;
  logic [31:0] shift_ff;
  logic [31:0] buf_acc_ff, buf_vel_ff, buf_pos_ff;
  logic [15:0] buf_cw_ff;
  logic [31:0] act_pos_ff;
  logic acc_chg_ff, cmderr_ff, busy_ff, done_ff;
  logic [2:0] busy_cnt_ff;
  logic [7:0] sint_ff;
  logic [7:0] sint_cnt_ff;
  logic [31:0] tick_cnt_ff;
  logic start_pend_ff;
  logic wr_acc, rd_acc, byte_ok, cmd_wr, data_wr, start_cmd, start_ok;
  logic [3:0] need;
  logic [1:0] which;
  logic [31:0] word32;

  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign rd_acc = PSEL && PENABLE && !PWRITE;
  assign byte_ok = !busy_ff; // see RULE22
  assign cmd_wr = wr_acc && PADDR == A_CMD && byte_ok;
  assign data_wr = wr_acc && PADDR == A_DATA && byte_ok;
  assign start_cmd = cmd_wr && PWDATA[7:0] == CMD_START; // see RULE17
  assign start_ok = !(IN_MOTION && acc_chg_ff); // see RULE18
  // four bytes per flagged parameter
  assign need = 4'(2'(cw_ff[CW_ACC_LD]) + cw_ff[CW_VEL_LD] + cw_ff[CW_POS_LD]) << 2; // see RULE24
  assign word32 = {shift_ff[23:0], PWDATA[7:0]};

  // parameter slot in fixed order acc, vel, pos
  always_comb begin
    logic [3:0] idx;
    idx = 4'(cnt_ff >> 2);
    which = 2'd2;
    if (cw_ff[CW_ACC_LD] && idx == 4'd0) begin // see RULE12
      which = 2'd0;
    end else if (cw_ff[CW_VEL_LD] && idx == 4'(cw_ff[CW_ACC_LD])) begin
      which = 2'd1;
    end
  end

  // command interpreter; bus timing is the same for all writes, busy follows command and data writes only
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_ff <= S_IDLE;
      cw_ff <= 16'h0000;
      cnt_ff <= 4'h0;
      shift_ff <= 32'h0;
    end else if (cmd_wr) begin
      state_ff <= PWDATA[7:0] == CMD_LOAD_TRAJ ? S_CW : S_IDLE;
      cnt_ff <= 4'h0;
    end else if (data_wr) begin
      unique case (state_ff)
        S_CW: begin // see RULE1
          cw_ff <= {cw_ff[7:0], PWDATA[7:0]};
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == 4'h1) begin
            cnt_ff <= 4'h0;
            state_ff <= ({cw_ff[7:0], PWDATA[7:0]} & 16'h002a) != 16'h0 ? S_DATA : S_IDLE;
          end
        end
        S_DATA: begin // see RULE11
          shift_ff <= word32;
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff + 4'h1 == need) begin
            state_ff <= S_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // primary buffers, relative add and range clamp
  function automatic logic [31:0] clamp_u(input logic [31:0] v); // see RULE13
    clamp_u = v > ACC_MAX ? ACC_MAX : v;
  endfunction
  function automatic logic [31:0] clamp_s(input logic [31:0] v); // see RULE14
    if ($signed(v) < $signed(POS_MIN)) clamp_s = POS_MIN;
    else if ($signed(v) > $signed(POS_MAX)) clamp_s = POS_MAX;
    else clamp_s = v;
  endfunction

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      buf_acc_ff <= 32'h0;
      buf_vel_ff <= 32'h0;
      buf_pos_ff <= 32'h0;
      buf_cw_ff <= 16'h0;
    end else begin
      if (data_wr && state_ff == S_CW && cnt_ff == 4'h1) begin
        buf_cw_ff <= {cw_ff[7:0], PWDATA[7:0]};
      end
      if (data_wr && state_ff == S_DATA && cnt_ff[1:0] == 2'd3) begin // see RULE10
        unique case (which)
          2'd0: buf_acc_ff <= clamp_u(cw_ff[CW_ACC_REL] ? buf_acc_ff + word32 : word32); // see RULE25
          2'd1: buf_vel_ff <= clamp_u(cw_ff[CW_VEL_REL] ? buf_vel_ff + word32 : word32);
          default: buf_pos_ff <= clamp_s(cw_ff[CW_POS_REL] ? buf_pos_ff + word32 : word32);
        endcase
      end
    end
  end

  // acceleration changed flag; set wins over the start clear
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      acc_chg_ff <= 1'b0;
    end else if (data_wr && state_ff == S_DATA && cnt_ff[1:0] == 2'd3 && which == 2'd0) begin
      acc_chg_ff <= 1'b1;
    end else if (start_cmd && start_ok) begin
      acc_chg_ff <= 1'b0;
    end
  end

  // command error: set wins over host clear
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cmderr_ff <= 1'b0;
    end else if (start_cmd && !start_ok) begin // see RULE18
      cmderr_ff <= 1'b1;
    end else if (wr_acc && PADDR == A_RSTI && !PWDATA[ST_CMDERR]) begin
      cmderr_ff <= 1'b0;
    end
  end

  // busy window after each accepted byte
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      busy_cnt_ff <= 3'h0;
      busy_ff <= 1'b0;
    end else if (cmd_wr || data_wr) begin
      busy_cnt_ff <= 3'(BUSY_CLKS - 1);
      busy_ff <= 1'b1;
    end else if (busy_cnt_ff != 3'h0) begin
      busy_cnt_ff <= busy_cnt_ff - 3'h1;
    end else begin
      busy_ff <= 1'b0;
    end
  end

  // sample interval divider
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sint_ff <= 8'h00;
      tick_cnt_ff <= 32'h0;
      sint_cnt_ff <= 8'h00;
      SAMPLE_TICK <= 1'b0;
    end else begin
      if (wr_acc && PADDR == A_SINT) begin
        sint_ff <= PWDATA[7:0];
      end
      SAMPLE_TICK <= 1'b0;
      if (tick_cnt_ff == 32'(SAMPLE_CLKS_P - 1)) begin // see RULE2
        tick_cnt_ff <= 32'h0;
        if (sint_cnt_ff >= sint_ff) begin
          sint_cnt_ff <= 8'h00;
          SAMPLE_TICK <= 1'b1;
        end else begin
          sint_cnt_ff <= sint_cnt_ff + 8'h01;
        end
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 32'h1;
      end
    end
  end

  // start request held until the sample boundary
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      start_pend_ff <= 1'b0;
    end else if (start_cmd && start_ok) begin
      start_pend_ff <= 1'b1; // see RULE20
    end else if (SAMPLE_TICK) begin
      start_pend_ff <= 1'b0;
    end
  end

  // working registers and stop handling
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      TGT_ACC <= 32'h0;
      TGT_VEL <= 32'h0;
      TGT_POS <= 32'h0;
      VEL_MODE <= 1'b0;
      FWD_DIR <= 1'b0;
      MOTOR_OFF <= 1'b1;
      DRIVE_CODE <= DRIVE_ZERO;
      SMOOTH_STOP <= 1'b0;
      IN_MOTION <= 1'b0;
      done_ff <= 1'b0;
    end else if (start_pend_ff && SAMPLE_TICK && !(start_cmd && start_ok)) begin // see RULE16
      TGT_ACC <= buf_acc_ff;
      TGT_VEL <= buf_vel_ff;
      VEL_MODE <= buf_cw_ff[CW_VMODE]; // see RULE4
      FWD_DIR <= buf_cw_ff[CW_VMODE] ? buf_cw_ff[CW_FWD] : FWD_DIR; // see RULE3 RULE23
      MOTOR_OFF <= buf_cw_ff[CW_OFF]; // see RULE6 RULE23
      DRIVE_CODE <= DRIVE_ZERO;
      SMOOTH_STOP <= buf_cw_ff[CW_SMOOTH]; // see RULE8
      TGT_POS <= buf_cw_ff[CW_ABRUPT] ? act_pos_ff : buf_pos_ff; // see RULE7
      IN_MOTION <= !(buf_cw_ff[CW_OFF] || buf_cw_ff[CW_ABRUPT]);
      done_ff <= buf_cw_ff[CW_OFF] || buf_cw_ff[CW_ABRUPT];
    end else if (IN_MOTION && !VEL_MODE && act_pos_ff == TGT_POS) begin
      IN_MOTION <= 1'b0; // see RULE5
      done_ff <= 1'b1;
    end else if (IN_MOTION && SMOOTH_STOP && act_pos_ff == TGT_POS) begin
      IN_MOTION <= 1'b0;
      done_ff <= 1'b1;
    end else if (wr_acc && PADDR == A_RSTI && !PWDATA[ST_DONE]) begin
      done_ff <= 1'b0;
    end
  end

  // present position, reported by the profile logic through software
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      act_pos_ff <= 32'h0;
    end else if (wr_acc && PADDR == A_ACTUAL) begin
      act_pos_ff <= PWDATA;
    end else if (wr_acc && PADDR == A_DONE && IN_MOTION) begin
      act_pos_ff <= TGT_POS;
    end
  end

  // apb answer: zero wait states, unmapped reads zero with error
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PRDATA <= 32'h0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
      if (PSEL && !PENABLE) begin
        unique case (PADDR)
          A_STATUS: PRDATA <= {24'h0, MOTOR_OFF, 4'h0, done_ff, cmderr_ff, busy_ff};
          A_SIGNALS: PRDATA <= {19'h0, FWD_DIR, VEL_MODE, 3'h0, MOTOR_OFF, 4'h0,
                                done_ff, cmderr_ff, acc_chg_ff};
          A_ACC: PRDATA <= buf_acc_ff;
          A_VEL: PRDATA <= buf_vel_ff;
          A_POS: PRDATA <= buf_pos_ff;
          A_ACTUAL: PRDATA <= act_pos_ff;
          A_SINT: PRDATA <= {24'h0, sint_ff};
          A_CMD, A_DATA, A_DONE, A_RSTI: PRDATA <= 32'h0;
          default: PSLVERR <= 1'b1;
        endcase
      end
    end
  end

  property p_busy_drop;
    @(posedge CLK) disable iff (SYS_RST)
      (wr_acc && busy_ff) |=> $stable(cw_ff) && $stable(buf_acc_ff) && !$rose(cmderr_ff);
  endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("byte taken while busy"); // see RULE22

  property p_err_start;
    @(posedge CLK) disable iff (SYS_RST)
      (start_cmd && IN_MOTION && acc_chg_ff) |=> cmderr_ff && !start_pend_ff;
  endproperty
  a_err_start: assert property (p_err_start) else $error("start not refused"); // see RULE18

  sequence s_start;
    start_pend_ff && SAMPLE_TICK && !(start_cmd && start_ok);
  endsequence
  property p_copy;
    @(posedge CLK) disable iff (SYS_RST)
      s_start |=> TGT_VEL == $past(buf_vel_ff);
  endproperty
  a_copy: assert property (p_copy) else $error("velocity not copied at start"); // see RULE16

  property p_hold;
    @(posedge CLK) disable iff (SYS_RST)
      !(start_pend_ff && SAMPLE_TICK) |=> $stable(TGT_VEL) && $stable(VEL_MODE);
  endproperty
  a_hold: assert property (p_hold) else $error("working value changed early"); // see RULE23

  property p_abrupt;
    @(posedge CLK) disable iff (SYS_RST)
      s_start ##0 buf_cw_ff[CW_ABRUPT] |=> TGT_POS == $past(act_pos_ff);
  endproperty
  a_abrupt: assert property (p_abrupt) else $error("abrupt stop target wrong"); // see RULE7

  property p_off;
    @(posedge CLK) disable iff (SYS_RST)
      s_start ##0 buf_cw_ff[CW_OFF] |=> MOTOR_OFF && DRIVE_CODE == DRIVE_ZERO;
  endproperty
  a_off: assert property (p_off) else $error("motor not turned off"); // see RULE6

  property p_pos_range;
    @(posedge CLK) disable iff (SYS_RST)
      $signed(buf_pos_ff) >= $signed(POS_MIN) && $signed(buf_pos_ff) <= $signed(POS_MAX);
  endproperty
  a_pos_range: assert property (p_pos_range) else $error("position out of range"); // see RULE14

  property p_vel_range;
    @(posedge CLK) disable iff (SYS_RST)
      buf_acc_ff <= ACC_MAX && buf_vel_ff <= ACC_MAX;
  endproperty
  a_vel_range: assert property (p_vel_range) else $error("rate out of range"); // see RULE13

  property p_dir_pos;
    @(posedge CLK) disable iff (SYS_RST)
      s_start ##0 !buf_cw_ff[CW_VMODE] |=> $stable(FWD_DIR) && !VEL_MODE;
  endproperty
  a_dir_pos: assert property (p_dir_pos) else $error("direction changed in position mode"); // see RULE3
endmodule
`default_nettype wire

/* File: test/tls_host.sv */
// Purpose: host model sending command and data bytes over apb
// Assumes: one byte per write, busy polled through the status word
// Notes: callers keep the host duties on stop bits, acc and restart timing
`timescale 1ns/100ps
`default_nettype none
module tls_host
  import tls_pkg::*;
(
  input wire logic CLK, // system clock
  input wire logic PREADY, // apb ready
  input wire logic [31:0] PRDATA, // apb read data
  input wire logic PSLVERR, // apb error
  output logic PSEL, // apb select
  output logic PENABLE, // apb access phase
  output logic PWRITE, // apb direction
  output logic [7:0] PADDR, // apb byte address
  output logic [31:0] PWDATA // apb write data
);
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // stale data must not look valid once released
    PWDATA <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic e;
    xfer(1'b0, a, 32'h0, v, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic e;
    xfer(1'b1, a, d, v, e);
  endtask
  task automatic idle_wait();
    logic [31:0] s;
    s = 32'h1;
    while (s[ST_BUSY] !== 1'b0) rd(A_STATUS, s);
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] b);
    idle_wait();
    wr(a, {24'h0, b});
  endtask
  task automatic word(input logic [15:0] w);
    put(A_DATA, w[15:8]);
    put(A_DATA, w[7:0]);
  endtask
  task automatic load(input logic [15:0] cw, input logic [31:0] acc, vel, pos);
    put(A_CMD, CMD_LOAD_TRAJ);
    word(cw);
    if (cw[CW_ACC_LD]) begin
      word(acc[31:16]);
      word(acc[15:0]);
    end
    if (cw[CW_VEL_LD]) begin
      word(vel[31:16]);
      word(vel[15:0]);
    end
    if (cw[CW_POS_LD]) begin
      word(pos[31:16]);
      word(pos[15:0]);
    end
  endtask
  task automatic start();
    put(A_CMD, CMD_START);
  endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: self-checking bench for trajectory load and start
// Assumes: short sample interval parameter for a quick run
// Notes: host model drives apb; bench compares ports and registers
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import tls_pkg::*;
  localparam int SCP = 8;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, vel_mode, fwd_dir;
  logic motor_off, smooth_stop, in_motion, sample_tick;
  logic [7:0] paddr, drive_code;
  logic [31:0] pwdata, prdata, tgt_acc, tgt_vel, tgt_pos, v;
  logic e;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int gap;
  always #2 clk = ~clk;
  tls_top #(.SAMPLE_CLKS_P(SCP)) i_tls_top (
    .CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TGT_ACC(tgt_acc), .TGT_VEL(tgt_vel), .TGT_POS(tgt_pos), .VEL_MODE(vel_mode),
    .FWD_DIR(fwd_dir), .MOTOR_OFF(motor_off), .DRIVE_CODE(drive_code),
    .SMOOTH_STOP(smooth_stop), .IN_MOTION(in_motion), .SAMPLE_TICK(sample_tick));
  tls_host i_tls_host (
    .CLK(clk), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata));
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic reg_is(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    i_tls_host.idle_wait();
    i_tls_host.rd(a, r);
    chk_word(r, exp);
  endtask
  task automatic flag_is(input int b, input logic exp);
    logic [31:0] r;
    i_tls_host.idle_wait();
    i_tls_host.rd(A_STATUS, r);
    chk_bit(r[b], exp);
  endtask
  task automatic wait_tick();
    while (sample_tick !== 1'b1) @(posedge clk);
  endtask
  // two ticks so a start that lands on a tick edge still counts
  task automatic ticks();
    repeat (2) begin
      @(posedge clk);
      wait_tick();
    end
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    chk_bit(motor_off, 1'b1);
    chk_word({24'h0, drive_code}, {24'h0, DRIVE_ZERO});
    flag_is(ST_OFF, 1'b1);
    i_tls_host.xfer(1'b0, 8'h3c, 32'h0, v, e);
    chk_bit(e, 1'b1);
    done("reset and unmapped");
    i_tls_host.load(16'h002a, 32'h10000, 32'h50000, 32'h1234);
    reg_is(A_ACC, 32'h10000);
    reg_is(A_VEL, 32'h50000);
    reg_is(A_POS, 32'h1234);
    chk_word(tgt_vel, 32'h0);
    i_tls_host.start();
    ticks();
    chk_word(tgt_acc, 32'h10000);
    chk_word(tgt_vel, 32'h50000);
    chk_word(tgt_pos, 32'h1234);
    chk_bit(motor_off, 1'b0);
    chk_bit(vel_mode, 1'b0);
    chk_bit(in_motion, 1'b1);
    done("load and start");
    // restart during motion after an acc change must be refused
    i_tls_host.load(16'h0020, 32'h20000, 32'h0, 32'h0);
    i_tls_host.start();
    ticks();
    chk_word(tgt_acc, 32'h10000);
    flag_is(ST_CMDERR, 1'b1);
    i_tls_host.put(A_RSTI, 8'h00);
    flag_is(ST_CMDERR, 1'b0);
    i_tls_host.put(A_DONE, 8'h00);
    repeat (2) @(posedge clk);
    chk_bit(in_motion, 1'b0);
    i_tls_host.start();
    ticks();
    chk_word(tgt_acc, 32'h20000);
    done("refused start");
    i_tls_host.load(16'h000c, 32'h0, 32'h10000, 32'h0);
    reg_is(A_VEL, 32'h60000);
    reg_is(A_ACC, 32'h20000);
    i_tls_host.put(A_CMD, CMD_LOAD_TRAJ);
    i_tls_host.wr(A_DATA, 32'hff);
    i_tls_host.word(16'h0008);
    i_tls_host.word(16'h0003);
    i_tls_host.word(16'h0000);
    reg_is(A_VEL, 32'h30000);
    flag_is(ST_CMDERR, 1'b0);
    done("relative and busy drop");
    i_tls_host.load(16'h1800, 32'h0, 32'h0, 32'h0);
    chk_bit(fwd_dir, 1'b0);
    i_tls_host.start();
    ticks();
    chk_bit(vel_mode, 1'b1);
    chk_bit(fwd_dir, 1'b1);
    i_tls_host.load(16'h0c00, 32'h0, 32'h0, 32'h0);
    i_tls_host.start();
    ticks();
    chk_bit(smooth_stop, 1'b1);
    i_tls_host.idle_wait();
    i_tls_host.wr(A_ACTUAL, 32'h777);
    i_tls_host.put(A_RSTI, 8'h00);
    flag_is(ST_DONE, 1'b0);
    i_tls_host.load(16'h0a00, 32'h0, 32'h0, 32'h0);
    i_tls_host.start();
    ticks();
    chk_word(tgt_pos, 32'h777);
    flag_is(ST_DONE, 1'b1);
    i_tls_host.load(16'h0900, 32'h0, 32'h0, 32'h0);
    chk_bit(motor_off, 1'b0);
    i_tls_host.start();
    ticks();
    chk_bit(motor_off, 1'b1);
    chk_word({24'h0, drive_code}, {24'h0, DRIVE_ZERO});
    done("velocity mode and stops");
    i_tls_host.load(16'h000a, 32'h0, 32'hffffffff, 32'h80000000);
    reg_is(A_VEL, ACC_MAX);
    reg_is(A_POS, POS_MIN);
    i_tls_host.idle_wait();
    i_tls_host.wr(A_SINT, 32'h2);
    ticks();
    wait_tick();
    @(posedge clk);
    gap = 1;
    while (sample_tick !== 1'b1) begin
      @(posedge clk);
      gap++;
    end
    chk_word(32'(gap), 32'(3 * SCP));
    done("limits and interval");
    give_verdict();
  end
endmodule
`default_nettype wire
